// File: pkg/jfcc_pkg.sv
// Package with constants and types for the fuse check control block.
// Summary of operation
// - After power-on reset, first falling edge on mode select enters fuse check mode.
// - Mode select low while power comes up enters fuse check mode without an edge.
// - Second rising edge of mode select since power-up leaves fuse check mode.
// - Once left, fuse check mode stays disabled until the next power-on reset.
// - Continuity path is on only while check mode is active and mode select is low.
// - A blown fuse refuses test access and forces the test port into bypass.
package jfcc_pkg;

  localparam logic [1:0] JFCC_RISE_LIMIT = 2'h2;
  localparam logic JFCC_TMS_IDLE = 1'h1;
  localparam logic [1:0] JFCC_CNT_RST = 2'h0;
  localparam logic [1:0] JFCC_UP_FIRST = 2'h2;
  localparam logic [1:0] JFCC_UP_LIVE = 2'h3;
  localparam logic JFCC_FUSE_SAFE = 1'h1;

  typedef enum {
    JFCC_ST_ARMED,
    JFCC_ST_ACTIVE,
    JFCC_ST_DONE
  } jfcc_state_t;

  typedef struct packed {
    logic fuse_check_current;
    logic check_active;
    logic bypass;
    logic access_enable;
  } jfcc_status_t;

  // Reset shows bypass only, the safe state.
  localparam jfcc_status_t JFCC_STATUS_RST = 4'h2;

endpackage

// File: hdl/jfcc_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ns
module jfcc_sync #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic q_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// File: hdl/jfcc_top.sv
// Fuse check mode control and fuse-blown bypass for the test port.
`timescale 1ns/1ns
module jfcc_top (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic TMS_PIN,
  input wire logic FUSE_BLOWN,
  output jfcc_pkg::jfcc_status_t STATUS
);
  logic tms_s;
  logic fuse_s;
  logic tms_prev_reg;
  logic tms_prev_next;
  logic [1:0] up_cnt_reg;
  logic [1:0] up_cnt_next;
  logic first;
  logic live;
  logic [1:0] rise_cnt_reg;
  logic [1:0] rise_cnt_next;
  jfcc_pkg::jfcc_state_t state_reg;
  jfcc_pkg::jfcc_state_t state_next;
  jfcc_pkg::jfcc_status_t status_reg;
  jfcc_pkg::jfcc_status_t status_next;
  logic fall;
  logic rise;

  jfcc_sync #(.RST_VAL(jfcc_pkg::JFCC_TMS_IDLE)) u_tms_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d(TMS_PIN),
    .q(tms_s)
  );

  jfcc_sync #(.RST_VAL(jfcc_pkg::JFCC_FUSE_SAFE)) u_fuse_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d(FUSE_BLOWN),
    .q(fuse_s)
  );

  function automatic logic is_fall(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  function automatic logic is_rise(input logic prev, input logic cur);
    return !prev && cur;
  endfunction

  // The rise that brings the count up to its limit ends fuse check mode.
  function automatic logic is_exit(input logic rise_now, input logic [1:0] cnt);
    return rise_now && (cnt == jfcc_pkg::JFCC_RISE_LIMIT - 2'h1);
  endfunction

  // The synchronisers show their reset level for two edges after release, so the
  // power-up level is judged only once the pin has really arrived, and edges after that.
  assign first = (up_cnt_reg == jfcc_pkg::JFCC_UP_FIRST);
  assign live = (up_cnt_reg == jfcc_pkg::JFCC_UP_LIVE);
  assign fall = live && is_fall(tms_prev_reg, tms_s);
  assign rise = live && is_rise(tms_prev_reg, tms_s);

  always_comb begin
    tms_prev_next = tms_s;
    up_cnt_next = up_cnt_reg;
    if (!live) begin
      up_cnt_next = up_cnt_reg + 2'h1;
    end
    rise_cnt_next = rise_cnt_reg;
    state_next = state_reg;
    if (rise && rise_cnt_reg != jfcc_pkg::JFCC_RISE_LIMIT) begin
      rise_cnt_next = rise_cnt_reg + 2'h1;
    end
    case (state_reg)
      jfcc_pkg::JFCC_ST_ARMED: begin
        if (first && !tms_s) begin
          state_next = jfcc_pkg::JFCC_ST_ACTIVE;
        end else if (fall) begin
          state_next = jfcc_pkg::JFCC_ST_ACTIVE;
        end
        if (is_exit(rise, rise_cnt_reg)) begin
          state_next = jfcc_pkg::JFCC_ST_DONE;
        end
      end
      jfcc_pkg::JFCC_ST_ACTIVE: begin
        if (is_exit(rise, rise_cnt_reg)) begin
          state_next = jfcc_pkg::JFCC_ST_DONE;
        end
      end
      jfcc_pkg::JFCC_ST_DONE: begin
        state_next = jfcc_pkg::JFCC_ST_DONE;
      end
      default: begin
        state_next = jfcc_pkg::JFCC_ST_DONE;
      end
    endcase
    status_next.check_active = (state_next == jfcc_pkg::JFCC_ST_ACTIVE);
    status_next.fuse_check_current = status_next.check_active && !tms_s;
    status_next.bypass = fuse_s;
    status_next.access_enable = !fuse_s;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tms_prev_reg <= jfcc_pkg::JFCC_TMS_IDLE;
      up_cnt_reg <= jfcc_pkg::JFCC_CNT_RST;
      rise_cnt_reg <= jfcc_pkg::JFCC_CNT_RST;
      state_reg <= jfcc_pkg::JFCC_ST_ARMED;
      status_reg <= jfcc_pkg::JFCC_STATUS_RST;
    end else begin
      tms_prev_reg <= tms_prev_next;
      up_cnt_reg <= up_cnt_next;
      rise_cnt_reg <= rise_cnt_next;
      state_reg <= state_next;
      status_reg <= status_next;
    end
  end

  assign STATUS = status_reg;

  AST_DONE_STICKY: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_reg == jfcc_pkg::JFCC_ST_DONE |=> state_reg == jfcc_pkg::JFCC_ST_DONE)
    else $error("Fuse check mode re-entered without reset.");

  AST_CURRENT_GATED: assert property (@(posedge CORE_CLK) disable iff (RST)
    STATUS.fuse_check_current |-> STATUS.check_active && !tms_prev_reg)
    else $error("Check current on outside active low phase.");

  AST_FALL_ENTERS: assert property (@(posedge CORE_CLK) disable iff (RST)
    fall && state_reg == jfcc_pkg::JFCC_ST_ARMED |=> STATUS.check_active)
    else $error("Falling edge did not enter fuse check mode.");

  AST_LOW_AT_UP: assert property (@(posedge CORE_CLK) disable iff (RST)
    first && !tms_s |=> STATUS.check_active)
    else $error("Low level at power-up did not enter fuse check mode.");

  sequence s_second_rise;
    is_exit(rise, rise_cnt_reg);
  endsequence

  AST_SECOND_RISE_EXITS: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_second_rise |=> !STATUS.check_active ##1 !STATUS.check_active)
    else $error("Second rising edge did not leave fuse check mode.");

  AST_BYPASS: assert property (@(posedge CORE_CLK) disable iff (RST)
    fuse_s |=> STATUS.bypass && !STATUS.access_enable)
    else $error("Blown fuse did not force bypass.");

  AST_RESET_CLEAR: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> rise_cnt_reg == 2'h0 && state_reg == jfcc_pkg::JFCC_ST_ARMED)
    else $error("Edge tracking not cleared by reset.");

  AST_CNT_BOUND: assert property (@(posedge CORE_CLK) disable iff (RST)
    rise_cnt_reg <= jfcc_pkg::JFCC_RISE_LIMIT)
    else $error("Rising edge count beyond limit.");

  // The status register moves on the same edge as the state, so the two always agree.
  sequence s_armed_idle;
    state_reg == jfcc_pkg::JFCC_ST_ARMED && !fall && !rise && !(first && !tms_s);
  endsequence

  AST_ARMED_WAITS: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_armed_idle |=> state_reg == jfcc_pkg::JFCC_ST_ARMED)
    else $error("Armed state left without an edge.");

  AST_STATE_MATCH: assert property (@(posedge CORE_CLK) disable iff (RST)
    STATUS.check_active == (state_reg == jfcc_pkg::JFCC_ST_ACTIVE))
    else $error("Mode flag disagrees with the mode state.");

  AST_ENTER_NEEDS_EDGE: assert property (@(posedge CORE_CLK) disable iff (RST)
    !STATUS.check_active && !fall && !(first && !tms_s) |=> !STATUS.check_active)
    else $error("Fuse check mode entered without a cause.");

  AST_INACTIVE_NO_CURRENT: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_reg != jfcc_pkg::JFCC_ST_ACTIVE |-> !STATUS.fuse_check_current)
    else $error("Check current on outside fuse check mode.");

  AST_CURRENT_FOLLOWS: assert property (@(posedge CORE_CLK) disable iff (RST)
    STATUS.check_active && !tms_prev_reg |-> STATUS.fuse_check_current)
    else $error("Check current off while active and pin low.");

  sequence s_first_rise;
    state_reg == jfcc_pkg::JFCC_ST_ACTIVE && rise && rise_cnt_reg == jfcc_pkg::JFCC_CNT_RST;
  endsequence

  AST_FIRST_RISE_STAYS: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_first_rise |=> STATUS.check_active && !STATUS.fuse_check_current)
    else $error("First rising edge left fuse check mode.");

  AST_NO_EXIT_EARLY: assert property (@(posedge CORE_CLK) disable iff (RST)
    STATUS.check_active && !rise |=> STATUS.check_active)
    else $error("Fuse check mode left without a rising edge.");

  AST_CNT_STEP: assert property (@(posedge CORE_CLK) disable iff (RST)
    rise && rise_cnt_reg != jfcc_pkg::JFCC_RISE_LIMIT
    |=> rise_cnt_reg == $past(rise_cnt_reg) + 2'h1)
    else $error("Rising edge not counted.");

  AST_CNT_HOLDS: assert property (@(posedge CORE_CLK) disable iff (RST)
    !rise |=> $stable(rise_cnt_reg))
    else $error("Rising edge count moved without an edge.");

  sequence s_done_edge;
    state_reg == jfcc_pkg::JFCC_ST_DONE && (fall || rise);
  endsequence

  AST_DONE_IGNORES_PIN: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_done_edge |=> !STATUS.check_active ##1 !STATUS.check_active)
    else $error("Pin edge re-entered fuse check mode.");

  AST_DONE_NO_CURRENT: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_reg == jfcc_pkg::JFCC_ST_DONE |-> !STATUS.check_active && !STATUS.fuse_check_current)
    else $error("Check current on after fuse check mode ended.");

  AST_ACCESS_OPEN: assert property (@(posedge CORE_CLK) disable iff (RST)
    !fuse_s |=> STATUS.access_enable && !STATUS.bypass)
    else $error("Intact fuse did not allow test access.");

  // Edges are held back until the synchronised pin is valid after each release.
  AST_UP_WINDOW: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> up_cnt_reg == jfcc_pkg::JFCC_CNT_RST && !fall && !rise)
    else $error("Edge tracking active right after reset.");
endmodule

// File: testbench/jfcc_adp.sv
// Adapter model that drives the mode select pin.
`timescale 1ns/1ns
module jfcc_adp (
  input wire logic clk,
  output logic tms
);
  initial begin
    tms = 1'h1;
  end
  task automatic drive(input logic v);
    @(posedge clk);
    #1 tms = v;
  endtask
endmodule

// File: testbench/jfcc_top_tb.sv
// Self-checking bench for the fuse check control block.
`timescale 1ns/1ns
module jfcc_top_tb;
  logic clk;
  logic rst = 1'h1;
  logic fuse = 1'h0;
  logic tms;
  jfcc_pkg::jfcc_status_t st;
  int miscompares = 0;
  int n_tests = 0;
  jfcc_top dut_u (.CORE_CLK(clk), .RST(rst), .TMS_PIN(tms), .FUSE_BLOWN(fuse), .STATUS(st));
  jfcc_adp adp_u (.clk(clk), .tms(tms));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic end_sim();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [3:0] exp);
    n_tests++;
    if (st !== exp) begin
      miscompares++;
      $display("ERROR %0t status %h expected %h", $time, st, exp);
    end
  endtask
  // Drives the pin, then lets the two sync stages and the register settle.
  task automatic step(input logic v, input logic [3:0] exp);
    adp_u.drive(v);
    repeat (5) @(posedge clk);
    #1 chk(exp);
  endtask
  task automatic do_reset(input logic v);
    adp_u.drive(v);
    #1 rst = 1'h1;
    repeat (20) @(posedge clk);
    #1 chk(4'h2);
    rst = 1'h0;
  endtask
  task automatic t_edges();
    do_reset(1'h1);
    step(1'h1, 4'h1);
    step(1'h0, 4'hD);
    step(1'h1, 4'h5);
    step(1'h0, 4'hD);
    step(1'h1, 4'h1);
    step(1'h0, 4'h1);
    step(1'h1, 4'h1);
    step(1'h0, 4'h1);
  endtask
  task automatic t_low_power_up();
    do_reset(1'h0);
    repeat (5) @(posedge clk);
    #1 chk(4'hD);
    step(1'h1, 4'h5);
  endtask
  task automatic t_fuse();
    step(1'h0, 4'hD);
    step(1'h1, 4'h1);
    @(posedge clk);
    #1 fuse = 1'h1;
    step(1'h0, 4'h2);
    step(1'h1, 4'h2);
  endtask
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    t_edges();
    t_low_power_up();
    t_fuse();
    end_sim();
  end
endmodule
